// ==== rtl/acs_pkg.sv ====
`default_nettype none
package acs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TIMING  = 8'h04;
    localparam logic [7:0] OFS_PORTCFG = 8'h08;
    localparam logic [7:0] OFS_RESULT  = 8'h0C;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_PORTIN  = 8'h14;

    // Field positions
    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_GO_BIT     = 1;
    localparam int unsigned CTRL_CHAN_LSB   = 2;
    localparam int unsigned TIM_CLK_LSB     = 0;
    localparam int unsigned TIM_ACQ_LSB     = 3;
    localparam int unsigned STAT_DONE_BIT   = 0;
    localparam int unsigned STAT_STATE_LSB  = 1;
    localparam int unsigned STAT_SAMPLE_BIT = 4;

    // Reset values
    localparam logic [2:0]  CLK_SEL_RST = 3'h0;
    localparam logic [2:0]  ACQ_SEL_RST = 3'h0;
    localparam logic [3:0]  CHAN_RST    = 4'h0;
    localparam logic [15:0] MASK_RST    = 16'hFFFF;
    localparam logic [11:0] RESULT_RST  = 12'h000;

    // Timing
    localparam real         CLK_PERIOD_NS  = 10.0;
    localparam real         RC_TAD_US      = 2.5;
    localparam int unsigned RC_TAD_CYC     = $rtoi(RC_TAD_US * 1000.0 / CLK_PERIOD_NS);
    localparam int unsigned OSC_PER_INSTR  = 4;
    localparam int unsigned DEFER_INSTR    = 1;
    localparam int unsigned REACQ_INSTR    = 2;
    localparam int unsigned DEFER_CYC      = DEFER_INSTR * OSC_PER_INSTR;
    localparam int unsigned REACQ_CYC      = REACQ_INSTR * OSC_PER_INSTR;
    localparam int unsigned CONV_TADS      = 13;
    localparam int unsigned DISCH_TADS     = 1;
    localparam int unsigned SAR_BITS       = 12;
    localparam logic [1:0]  RC_SEL_CODE    = 2'h3;

    // Acquisition length in bit periods per code; code 0 is manual
    localparam logic [4:0] ACQ_TADS [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                            5'h08, 5'h0C, 5'h10, 5'h14};

    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_DISCH  = 3'h1,
        ST_SAMPLE = 3'h3,
        ST_ACQ    = 3'h2,
        ST_CONV   = 3'h6,
        ST_WAIT   = 3'h7,
        ST_DEFER  = 3'h5
    } acs_state_t;

endpackage
`default_nettype wire

// ==== rtl/acs_tad_gen.sv ====
`default_nettype none
module acs_tad_gen
    import acs_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    input  wire logic       osc_stopped,
    output logic            tad_tick
);
    if (RC_TAD_CYC >= (1 << CNT_W) || CNT_W < 7) begin : g_bad_cnt_w
        $error("acs_tad_gen: CNT_W too small");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] limit;
    logic             use_rc;
    logic [2:0]       exp_sel;

    always_comb begin
        use_rc   = (clk_sel[1:0] == RC_SEL_CODE);
        // Codes 000,100,001,101,010,110 give 2..64 oscillator periods
        exp_sel  = 3'({clk_sel[1:0], clk_sel[2]}) + 3'h1;
        limit    = use_rc ? CNT_W'(RC_TAD_CYC) : CNT_W'(1) << exp_sel;
        tad_tick = 1'b0;
        cnt_next = cnt_reg;
        if (!run) begin
            cnt_next = '0;
        end else if (use_rc || !osc_stopped) begin
            // RC source keeps running while the oscillator is stopped
            if (cnt_reg == limit - CNT_W'(1)) begin
                cnt_next = '0;
                tad_tick = 1'b1;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            cnt_reg <= '0;
        else if (ce)
            cnt_reg <= cnt_next;
    end
endmodule
`default_nettype wire

// ==== rtl/acs_adc_seq.sv ====
`default_nettype none
module acs_adc_seq
    import acs_pkg::*;
#(
    parameter int unsigned N_PINS = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              osc_stopped,
    input  wire logic              cmp_in,
    input  wire logic [N_PINS-1:0] port_pins,
    output logic                   sample_en,
    output logic                   discharge_en,
    output logic                   conv_busy,
    output logic [11:0]            sar_code,
    output logic [3:0]             channel_select
);
    if (N_PINS < 1 || N_PINS > 16) begin : g_bad_n_pins
        $error("acs_adc_seq: N_PINS must be 1..16");
    end

    // Register state
    logic                converter_enable_bit_reg, converter_enable_bit_next;
    logic                go_reg, go_next;
    logic [3:0]          chan_reg, chan_next;
    logic [2:0]          conv_clock_select_reg, conv_clock_select_next;
    logic [2:0]          acq_time_select_reg, acq_time_select_next;
    logic [N_PINS-1:0]   analog_mask_reg, analog_mask_next;
    logic [11:0]         result_pair_reg, result_pair_next;
    logic                conv_done_irq_flag_reg, conv_done_irq_flag_next;
    logic [31:0]         prdata_reg, prdata_next;
    logic                rd_valid_reg, rd_valid_next;

    // Sequencer state
    acs_state_t          state_reg, state_next;
    logic [4:0]          cnt_reg, cnt_next;
    logic [11:0]         sar_reg, sar_next;

    // Pin synchronisers
    logic [N_PINS-1:0]   pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_filt_reg;
    logic                cmp_s1_reg, cmp_s2_reg, cmp_s3_reg, cmp_filt_reg;

    logic                tad_tick;
    logic                tad_run;
    logic                wr_en;
    logic                rd_setup;
    logic                conv_done;
    logic                abort_req;
    logic [N_PINS-1:0]   port_read;
    logic                addr_ok;
    logic [11:0]         bit_mask;

    acs_tad_gen #(
        .CNT_W (8)
    ) u_tad_gen (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .ce          (ce),
        .run         (tad_run),
        .clk_sel     (conv_clock_select_reg),
        .osc_stopped (osc_stopped),
        .tad_tick    (tad_tick)
    );

    // Three-stage pin capture; a change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            pin_s3_reg   <= '0;
            pin_filt_reg <= '0;
            cmp_s1_reg   <= 1'b0;
            cmp_s2_reg   <= 1'b0;
            cmp_s3_reg   <= 1'b0;
            cmp_filt_reg <= 1'b0;
        end else if (ce) begin
            pin_s1_reg <= port_pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            for (int i = 0; i < N_PINS; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i])
                    pin_filt_reg[i] <= pin_s3_reg[i];
            end
            cmp_s1_reg <= cmp_in;
            cmp_s2_reg <= cmp_s1_reg;
            cmp_s3_reg <= cmp_s2_reg;
            if (cmp_s2_reg == cmp_s3_reg)
                cmp_filt_reg <= cmp_s3_reg;
        end
    end

    // Analog pins read low; digital pins pass through
    assign port_read = pin_filt_reg & ~analog_mask_reg;

    assign pready  = psel & penable & ce & rd_valid_reg;
    assign wr_en   = pready & pwrite;
    assign rd_setup = psel & ~rd_valid_reg;
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_TIMING) ||
                     (paddr == OFS_PORTCFG) || (paddr == OFS_RESULT) ||
                     (paddr == OFS_STATUS) || (paddr == OFS_PORTIN);
    assign pslverr = pready & ~addr_ok;
    assign prdata  = prdata_reg;

    // Completion on the last bit period, abort whenever go drops mid-flight
    assign conv_done = (state_reg == ST_CONV) && tad_tick &&
                       (cnt_reg == 5'(CONV_TADS - 1)) && go_reg;
    assign abort_req = !go_reg && ((state_reg == ST_CONV) || (state_reg == ST_ACQ) ||
                                   (state_reg == ST_DEFER));

    always_comb begin
        converter_enable_bit_next = converter_enable_bit_reg;
        go_next                   = go_reg;
        chan_next                 = chan_reg;
        conv_clock_select_next    = conv_clock_select_reg;
        acq_time_select_next      = acq_time_select_reg;
        analog_mask_next          = analog_mask_reg;
        result_pair_next          = result_pair_reg;
        conv_done_irq_flag_next   = conv_done_irq_flag_reg;
        prdata_next               = prdata_reg;
        rd_valid_next             = rd_valid_reg;

        if (conv_done) begin
            go_next          = 1'b0;
            result_pair_next = sar_next;
        end
        if (rd_setup) begin
            rd_valid_next = 1'b1;
            prdata_next   = 32'h0000_0000;
            unique case (paddr)
                OFS_CTRL: begin
                    prdata_next[CTRL_EN_BIT]             = converter_enable_bit_reg;
                    prdata_next[CTRL_GO_BIT]             = go_reg;
                    prdata_next[CTRL_CHAN_LSB +: 4]      = chan_reg;
                end
                OFS_TIMING: begin
                    prdata_next[TIM_CLK_LSB +: 3]        = conv_clock_select_reg;
                    prdata_next[TIM_ACQ_LSB +: 3]        = acq_time_select_reg;
                end
                OFS_PORTCFG: prdata_next[N_PINS-1:0]     = analog_mask_reg;
                OFS_RESULT:  prdata_next[11:0]           = result_pair_reg;
                OFS_STATUS: begin
                    prdata_next[STAT_DONE_BIT]           = conv_done_irq_flag_reg;
                    prdata_next[STAT_STATE_LSB +: 3]     = state_reg;
                    prdata_next[STAT_SAMPLE_BIT]         = sample_en;
                end
                OFS_PORTIN:  prdata_next[N_PINS-1:0]     = port_read;
                default:     prdata_next                 = 32'h0000_0000;
            endcase
        end
        if (pready)
            rd_valid_next = 1'b0;
        if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: begin
                    converter_enable_bit_next = pwdata[CTRL_EN_BIT];
                    go_next   = pwdata[CTRL_GO_BIT] & pwdata[CTRL_EN_BIT];
                    chan_next = pwdata[CTRL_CHAN_LSB +: 4];
                end
                OFS_TIMING: begin
                    conv_clock_select_next = pwdata[TIM_CLK_LSB +: 3];
                    acq_time_select_next   = pwdata[TIM_ACQ_LSB +: 3];
                end
                OFS_PORTCFG: analog_mask_next = pwdata[N_PINS-1:0];
                // Software value stays until the next completed conversion
                OFS_RESULT:  if (!conv_done) result_pair_next = pwdata[11:0];
                OFS_STATUS: begin
                    if (pwdata[STAT_DONE_BIT])
                        conv_done_irq_flag_next = 1'b0;
                end
                default: ;
            endcase
        end
        // Set wins over a same-cycle clear
        if (conv_done)
            conv_done_irq_flag_next = 1'b1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            converter_enable_bit_reg <= 1'b0;
            go_reg                   <= 1'b0;
            chan_reg                 <= CHAN_RST;
            conv_clock_select_reg    <= CLK_SEL_RST;
            acq_time_select_reg      <= ACQ_SEL_RST;
            analog_mask_reg          <= MASK_RST[N_PINS-1:0];
            result_pair_reg          <= RESULT_RST;
            conv_done_irq_flag_reg   <= 1'b0;
            prdata_reg               <= 32'h0000_0000;
            rd_valid_reg             <= 1'b0;
        end else if (ce) begin
            converter_enable_bit_reg <= converter_enable_bit_next;
            go_reg                   <= go_next;
            chan_reg                 <= chan_next;
            conv_clock_select_reg    <= conv_clock_select_next;
            acq_time_select_reg      <= acq_time_select_next;
            analog_mask_reg          <= analog_mask_next;
            result_pair_reg          <= result_pair_next;
            conv_done_irq_flag_reg   <= conv_done_irq_flag_next;
            prdata_reg               <= prdata_next;
            rd_valid_reg             <= rd_valid_next;
        end
    end

    // Sequencer. Idle mode is not an input: the bit clock keeps running.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sar_next   = sar_reg;
        bit_mask   = 12'h800 >> cnt_reg;
        tad_run    = (state_reg == ST_DISCH) || (state_reg == ST_ACQ) ||
                     (state_reg == ST_CONV);
        if (!converter_enable_bit_reg) begin
            state_next = ST_OFF;
            cnt_next   = 5'h00;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    state_next = ST_DISCH;
                    cnt_next   = 5'h00;
                end
                ST_DISCH: begin
                    if (tad_tick) begin
                        if (cnt_reg == 5'(DISCH_TADS - 1)) begin
                            state_next = ST_SAMPLE;
                            cnt_next   = 5'h00;
                        end else begin
                            cnt_next = cnt_reg + 5'h01;
                        end
                    end
                end
                // Channel and pin direction play no part in starting
                ST_SAMPLE: begin
                    if (go_reg) begin
                        cnt_next = 5'h00;
                        if (acq_time_select_reg == 3'h0) begin
                            state_next = ST_DEFER;
                        end else begin
                            state_next = ST_ACQ;
                        end
                    end
                end
                ST_DEFER: begin
                    if (abort_req) begin
                        state_next = ST_WAIT;
                        cnt_next   = 5'h00;
                    end else if (cnt_reg == 5'(DEFER_CYC - 1)) begin
                        state_next = ST_CONV;
                        cnt_next   = 5'h00;
                        sar_next   = 12'h800;
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
                ST_ACQ: begin
                    if (abort_req) begin
                        state_next = ST_WAIT;
                        cnt_next   = 5'h00;
                    end else if (tad_tick) begin
                        if (cnt_reg == ACQ_TADS[acq_time_select_reg] - 5'h01) begin
                            state_next = ST_CONV;
                            cnt_next   = 5'h00;
                            sar_next   = 12'h800;
                        end else begin
                            cnt_next = cnt_reg + 5'h01;
                        end
                    end
                end
                ST_CONV: begin
                    if (abort_req) begin
                        state_next = ST_WAIT;
                        cnt_next   = 5'h00;
                    end else if (tad_tick) begin
                        if (cnt_reg < 5'(SAR_BITS)) begin
                            // Comparator high keeps the trial bit
                            if (!cmp_filt_reg)
                                sar_next = sar_reg & ~bit_mask;
                            sar_next = sar_next | (bit_mask >> 1);
                        end
                        if (cnt_reg == 5'(CONV_TADS - 1)) begin
                            state_next = ST_WAIT;
                            cnt_next   = 5'h00;
                        end else begin
                            cnt_next = cnt_reg + 5'h01;
                        end
                    end
                end
                ST_WAIT: begin
                    if (cnt_reg == 5'(REACQ_CYC - 1)) begin
                        state_next = ST_DISCH;
                        cnt_next   = 5'h00;
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_next = ST_OFF;
                    cnt_next   = 5'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_OFF;
            cnt_reg   <= 5'h00;
            sar_reg   <= 12'h000;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            sar_reg   <= sar_next;
        end
    end

    assign sample_en      = (state_reg == ST_SAMPLE) || (state_reg == ST_ACQ);
    assign discharge_en   = (state_reg == ST_DISCH);
    assign conv_busy      = (state_reg == ST_CONV);
    assign sar_code       = sar_reg;
    assign channel_select = chan_reg;

    a_port_mask: assert property (@(posedge clk_sys) disable iff (rst)
        (port_read & analog_mask_reg) == '0)
        else $error("analog pin read back nonzero");

    a_disch_first: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(sample_en) |-> $past(state_reg) == ST_DISCH)
        else $error("sampling began without discharge");

    a_manual_defer: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_reg == ST_SAMPLE && go_reg && converter_enable_bit_reg
         && acq_time_select_reg == 3'h0) |=> (state_reg == ST_DEFER && !sample_en))
        else $error("manual start not deferred");

    a_defer_len: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == ST_DEFER) |-> cnt_reg < 5'(DEFER_CYC))
        else $error("defer longer than one instruction");

    a_acq_to_conv: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && converter_enable_bit_reg && go_reg && state_reg == ST_ACQ && tad_tick
         && cnt_reg == ACQ_TADS[acq_time_select_reg] - 5'h01)
        |=> (state_reg == ST_CONV && sar_reg == 12'h800))
        else $error("acquisition did not end in conversion");

    a_abort_keeps: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && converter_enable_bit_reg && state_reg == ST_CONV && !go_reg)
        |=> (state_reg == ST_WAIT && $stable(result_pair_reg)))
        else $error("abort did not stop conversion or changed result");

    a_done_effect: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && converter_enable_bit_reg && conv_done && !wr_en)
        |=> (!go_reg && conv_done_irq_flag_reg && state_reg == ST_WAIT))
        else $error("completion side effects missing");

    a_conv_count: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == ST_CONV) |-> cnt_reg < 5'(CONV_TADS))
        else $error("conversion exceeded thirteen bit periods");

    a_reacq_wait: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && converter_enable_bit_reg && state_reg == ST_WAIT
         && cnt_reg == 5'(REACQ_CYC - 1)) |=> state_reg == ST_DISCH)
        else $error("re-acquisition not started after wait");

    a_no_overlap: assert property (@(posedge clk_sys) disable iff (rst)
        !(sample_en && conv_busy))
        else $error("sampling during conversion");

endmodule
`default_nettype wire

// ==== tb/acs_afe_model.sv ====
`default_nettype none
module acs_afe_model (
    input  wire logic [11:0] level,
    input  wire logic [11:0] sar_code,
    output logic             cmp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Held level against trial code; channel and pins never gate it
    // Pins are driven by the bench but not wired to this model, so only the analog level converts
    assign cmp_in = (level >= sar_code);
endmodule
`default_nettype wire

// ==== tb/acs_adc_seq_tb_top.sv ====
`default_nettype none
module acs_adc_seq_tb_top
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, e, cmp_in, sample_en, discharge_en, conv_busy;
    logic        disch_seen = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [15:0] port_pins = 16'h0000;
    logic [11:0] level = 12'h000, sar_code;
    logic [3:0]  channel_select;
    int          n_fail = 0, n_compared = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    acs_adc_seq dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        // Oscillator never stops: no sleep runs, source fixed per conversion
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_stopped(1'b0),
        .cmp_in(cmp_in), .port_pins(port_pins), .sample_en(sample_en),
        .discharge_en(discharge_en), .conv_busy(conv_busy), .sar_code(sar_code),
        .channel_select(channel_select));
    acs_afe_model afe_u (.level(level), .sar_code(sar_code), .cmp_in(cmp_in));
    always @(posedge clk_sys) begin
        if (discharge_en === 1'b1) disch_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Read before the edge's own updates land, so these are the sampled values
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_state(input logic [2:0] s);
        repeat (150) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (q[3:1] === s) break;
        end
        chk({29'h0, q[3:1]}, {29'h0, s});
    endtask
    task automatic close_out();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        apb(1'b0, OFS_TIMING, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, OFS_PORTCFG, 32'h0);
        chk(q, 32'h0000FFFF);
        apb(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, 8'h3C, 32'hFFFF);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_portin();
        port_pins <= 16'hA5A5;
        apb(1'b1, OFS_PORTCFG, 32'h00FF);
        repeat (8) @(posedge clk_sys);
        apb(1'b0, OFS_PORTIN, 32'h0);
        chk(q, 32'h0000A500);
        $display("test portin done");
    endtask
    task automatic t_conv();
        apb(1'b1, OFS_TIMING, 32'h02);
        apb(1'b1, OFS_CTRL, 32'h15);
        wait_state(3'h3);
        level <= 12'hA5C;
        repeat (200) @(posedge clk_sys);
        apb(1'b1, OFS_CTRL, 32'h17);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({29'h0, q[3:1]}, 32'h5);
        chk({28'h0, channel_select}, 32'h5);
        repeat (300) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (q[0] === 1'b1) break;
        end
        chk({31'h0, q[0]}, 32'h1);
        apb(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h0A5C);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h15);
        apb(1'b1, OFS_STATUS, 32'h1);
        $display("test conv done");
    endtask
    task automatic t_abort();
        apb(1'b1, OFS_TIMING, 32'h12);
        apb(1'b1, OFS_RESULT, 32'h123);
        wait_state(3'h3);
        apb(1'b1, OFS_CTRL, 32'h17);
        repeat (300) @(posedge clk_sys);
        // Four 32-clock acquisition periods are over, so converting now
        chk({31'h0, conv_busy}, 32'h1);
        disch_seen <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h15);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({29'h0, q[3:1]}, 32'h7);
        apb(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h123);
        wait_state(3'h3);
        chk({31'h0, disch_seen}, 32'h1);
        $display("test abort done");
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_portin();
        t_conv();
        t_abort();
        close_out();
    end
endmodule
`default_nettype wire
